/* File: core/disk_read_pkg.sv */
// Constants, field layouts and carrier types for the disk track read sequencer.
// Assumes a 50 MHz APB clock and a drive that presents characters with area tags.
package disk_read_pkg;

	localparam int CLK_NS = 20;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_ADDR_LO = 8'h04;
	localparam logic [7:0] OFS_ADDR_HI = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;
	localparam logic [7:0] OFS_DATA    = 8'h10;

	// Control word fields
	localparam int CTRL_ORDER_LSB = 0;
	localparam int CTRL_READ_BIT  = 4;
	localparam int CTRL_STOP_BIT  = 5;
	localparam int CTRL_WIDE_BIT  = 6;

	// Status word fields
	localparam int STS_BUSY     = 0;
	localparam int STS_END_NORM = 1;
	localparam int STS_END_UNUS = 2;
	localparam int STS_NRF      = 3;
	localparam int STS_DCHK     = 4;
	localparam int STS_INOP     = 5;
	localparam int STS_SRV      = 6;
	localparam int STS_OVERRUN  = 7;
	localparam int STS_HEAD_LSB = 8;

	// Operation codes held in the order field
	localparam logic [3:0] OP_SINGLE = 4'h1;
	localparam logic [3:0] OP_TWA    = 4'h2;
	localparam logic [3:0] OP_HOME   = 4'h5;
	localparam logic [3:0] OP_TRACK  = 4'h6;
	localparam logic [3:0] OP_CYL    = 4'hB;

	// Area tags from the drive
	localparam logic [1:0] AREA_NONE = 2'h0;
	localparam logic [1:0] AREA_HA   = 2'h1;
	localparam logic [1:0] AREA_RA   = 2'h2;
	localparam logic [1:0] AREA_REC  = 2'h3;

	// Home address layout: four track digits, flag byte, two identifiers
	localparam logic [3:0] HA_FLAG_IDX = 4'h4;
	localparam logic [3:0] TRACK_POS   = 4'h2;
	localparam logic [3:0] ID_POS      = 4'h6;
	localparam logic [3:0] ADDR_LAST   = 4'h7;

	localparam logic [5:0] HEAD_MAX   = 6'h27;
	localparam logic [5:0] SPARE_BASE = 6'h27;
	localparam logic [3:0] ACC_NUM    = 4'h2;
	localparam logic [3:0] MOD_NUM    = 4'h2;
	localparam logic [7:0] DEC_TEN    = 8'h0A;

	// Service request spacing: least average time per character
	localparam int PACE6_NS   = 11100;
	localparam int PACE8_NS   = 14200;
	localparam int SQUELCH_NS = 2000;
	localparam logic [9:0] PACE6_CYC = 10'((PACE6_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] PACE8_CYC = 10'((PACE8_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [9:0] SQ_CYC    = 10'((SQUELCH_NS + CLK_NS - 1) / CLK_NS);

	typedef struct packed {
		logic       early_index;
		logic       strobe;
		logic       area_end;
		logic       check_err;
		logic       last_rec;
		logic [1:0] area;
		logic [7:0] ch;
		logic       override;
		logic [3:0] powered;
	} drive_in_type;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SQUELCH,
		ST_SEARCH,
		ST_SEEK_HA,
		ST_XFER
	} state_type;

endpackage

/* File: core/disk_track_read_sequencer.sv */
// Read-side sequencer: APB register slave toward the processor, tagged character
// stream from the drive. Drive inputs are asynchronous and resynchronised here.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module disk_track_read_sequencer
	import disk_read_pkg::*;
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire drive_in_type drive_in,
	output logic      [5:0]   head_addr,
	output logic              head_load,
	output logic              squelch,
	output logic      [3:0]   access_select,
	output logic              srv_req,
	output logic              op_end
);

	drive_in_type s1_q, s2_q, s3_q;
	state_type    st_q;
	logic [7:0][5:0] addr_q;
	logic [3:0]  mode_q;
	logic        wide_q;
	logic [5:0]  head_q;
	logic [3:0]  acc_q;
	logic [3:0]  cidx_q;
	logic [9:0]  sq_q;
	logic [9:0]  pace_q;
	logic [7:0]  hold_q;
	logic [7:0]  data_q;
	logic [31:0] prdata_q;
	logic        hold_v_q, srv_q, stop_q, miss_q, flag_q, nxt_q, idx_q;
	logic        end_n_q, end_u_q, nrf_q, dc_q, inop_q, ovr_q;
	logic        head_load_q, op_end_q;

	// Pin inputs: the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= drive_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	wire strb   = s2_q.strobe & ~s3_q.strobe;
	wire eoa    = s2_q.area_end & ~s3_q.area_end;
	wire idx_ev = s2_q.early_index & ~s3_q.early_index;
	wire is_ha  = s2_q.area == AREA_HA;
	wire is_ra  = s2_q.area == AREA_RA;
	wire is_rec = s2_q.area == AREA_REC;
	wire dc_now = eoa & s2_q.check_err;
	wire idle   = st_q == ST_IDLE;

	wire m_hao = mode_q == OP_HOME;
	wire m_trk = mode_q == OP_TRACK;
	wire m_twa = mode_q == OP_TWA;
	wire m_cyl = mode_q == OP_CYL;
	wire m_sro = mode_q == OP_SINGLE;
	wire valid_op = m_hao | m_trk | m_twa | m_cyl | m_sro;

	// APB decode
	wire acc_ph   = psel & penable;
	wire wr       = acc_ph & pwrite;
	wire rd       = acc_ph & ~pwrite;
	wire hit_ctrl = paddr == OFS_CTRL;
	wire hit_alo  = paddr == OFS_ADDR_LO;
	wire hit_ahi  = paddr == OFS_ADDR_HI;
	wire hit_sts  = paddr == OFS_STATUS;
	wire hit_dat  = paddr == OFS_DATA;
	wire mapped   = hit_ctrl | hit_alo | hit_ahi | hit_sts | hit_dat;
	wire [3:0] order_f = pwdata[CTRL_ORDER_LSB +: 4];
	wire order_wr = wr & hit_ctrl & idle & (order_f != 4'h0);
	wire read_wr  = wr & hit_ctrl & idle & pwdata[CTRL_READ_BIT] & ~order_wr;
	wire stop_wr  = wr & hit_ctrl & ~idle & pwdata[CTRL_STOP_BIT];
	wire stat_rd  = rd & hit_sts;
	wire data_rd  = rd & hit_dat;

	// Access selection from access and module digits
	wire [3:0] acc_dig = addr_q[0][3:0];
	wire [3:0] mod_dig = addr_q[1][3:0];
	wire [1:0] acc_idx = {acc_dig[0], mod_dig[0]};
	wire acc_ok   = (acc_dig < ACC_NUM) & (mod_dig < MOD_NUM);
	wire inop_now = ~acc_ok | ~s2_q.powered[acc_idx];
	wire [7:0] hs = 8'(addr_q[4][3:0]) * DEC_TEN + 8'(addr_q[5][3:0]);

	// Position of the current character within the stored address
	logic [3:0] cpos;
	assign cpos = ~is_ha ? cidx_q :
		(cidx_q < HA_FLAG_IDX) ? 4'(cidx_q + TRACK_POS) :
		(cidx_q == HA_FLAG_IDX) ? 4'h0 : 4'(cidx_q + 4'h1);

	function automatic logic char_miss(input logic [3:0] pos, input logic [5:0] c,
		input logic [5:0] a);
		if (pos < TRACK_POS || pos > ADDR_LAST)
			char_miss = 1'b0;
		else if (pos < ID_POS)
			char_miss = c[3:0] != a[3:0];
		else
			char_miss = c != a;
	endfunction

	function automatic logic [2:0] spare_of(input logic [2:0] f);
		case (f)
			3'h1: spare_of = 3'h1;
			3'h2: spare_of = 3'h2;
			3'h4: spare_of = 3'h3;
			3'h5: spare_of = 3'h4;
			3'h6: spare_of = 3'h5;
			3'h7: spare_of = 3'h6;
			default: spare_of = 3'h0;
		endcase
	endfunction

	wire       cmiss  = char_miss(cpos, s2_q.ch[5:0], addr_q[cpos[2:0]]);
	wire [2:0] surf   = spare_of(s2_q.ch[2:0]);
	wire       flag_c = strb & is_ha & (cidx_q == HA_FLAG_IDX);
	wire       spare  = flag_c & (surf != 3'h0) & ~flag_q &
		(st_q == ST_SEEK_HA || st_q == ST_SEARCH);
	wire       ovr_sw = s2_q.override;

	// Home address and record address decisions
	wire hao_go   = st_q == ST_SEEK_HA & m_hao & ~ovr_sw & flag_c & surf == 3'h0;
	wire hao_ovr  = st_q == ST_SEEK_HA & m_hao & ovr_sw & strb & is_ha;
	wire ha_end   = st_q == ST_SEEK_HA & ~m_hao & eoa & is_ha & ~flag_q;
	wire ha_rej   = (ha_end & miss_q & ~nxt_q) | (hao_go & miss_q);
	wire ha_pass  = (ha_end & ~(miss_q & ~nxt_q)) | (hao_go & ~miss_q);
	wire nrf_sro  = st_q == ST_SEARCH & idx_ev & idx_q;
	wire nrf_set  = ha_rej | nrf_sro;
	wire ra_match = st_q == ST_SEARCH & eoa & is_ra & ~miss_q;

	// Transfer and end conditions
	wire rec_end  = eoa & is_rec;
	wire step_ok  = m_cyl & (head_q < HEAD_MAX) & ~stop_q & ~dc_now;
	wire cyl_step = st_q == ST_XFER & rec_end & s2_q.last_rec & step_ok;
	logic xfer_end;
	always_comb begin
		xfer_end = 1'b0;
		if (st_q == ST_XFER) begin
			if (m_hao)
				xfer_end = idx_ev | (rec_end & stop_q);
			else if (m_sro)
				xfer_end = rec_end;
			else if (m_twa | m_cyl)
				xfer_end = rec_end & (stop_q | dc_now | (s2_q.last_rec & ~step_ok));
			else
				xfer_end = rec_end & (stop_q | s2_q.last_rec);
		end
	end
	wire early = stop_q & (st_q == ST_SQUELCH || st_q == ST_SEEK_HA || st_q == ST_SEARCH);
	wire fin   = nrf_set | xfer_end | early;
	wire fin_u = nrf_set | dc_q | dc_now;

	logic xfer_area;
	assign xfer_area = m_hao ? 1'b1 : m_trk ? (is_ra | is_rec) : is_rec;
	wire push = strb & ~stop_q & ((st_q == ST_XFER & xfer_area) | hao_ovr);
	wire move = hold_v_q & (pace_q == 10'h000) & ~srv_q;
	wire clr  = (stat_rd | order_wr) & idle;

	// Sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q        <= ST_IDLE;
			head_q      <= '0;
			acc_q       <= '0;
			stop_q      <= 1'b0;
			miss_q      <= 1'b0;
			flag_q      <= 1'b0;
			nxt_q       <= 1'b0;
			idx_q       <= 1'b0;
			sq_q        <= '0;
			head_load_q <= 1'b0;
			op_end_q    <= 1'b0;
		end else begin
			head_load_q <= 1'b0;
			op_end_q    <= 1'b0;
			if (stop_wr)
				stop_q <= 1'b1;
			if (eoa) begin
				miss_q <= 1'b0;
				flag_q <= 1'b0;
			end else if (strb & ~flag_c)
				miss_q <= miss_q | cmiss;
			if (spare) begin
				head_q      <= 6'(SPARE_BASE + 6'(surf));
				head_load_q <= 1'b1;
				flag_q      <= 1'b1;
			end
			case (st_q)
				ST_IDLE: begin
					if (read_wr & valid_op & ~inop_now) begin
						head_q      <= hs[5:0];
						head_load_q <= 1'b1;
						acc_q       <= 4'h1 << acc_idx;
						stop_q      <= 1'b0;
						miss_q      <= 1'b0;
						flag_q      <= 1'b0;
						nxt_q       <= 1'b0;
						idx_q       <= 1'b0;
						sq_q        <= SQ_CYC;
						st_q        <= m_sro ? ST_SQUELCH : ST_SEEK_HA;
					end else if (read_wr)
						op_end_q <= 1'b1;
				end
				ST_SQUELCH: begin
					sq_q <= sq_q - 10'h001;
					if (sq_q == 10'h001)
						st_q <= ST_SEARCH;
				end
				ST_SEARCH: begin
					if (idx_ev)
						idx_q <= 1'b1;
					if (ra_match)
						st_q <= ST_XFER;
				end
				ST_SEEK_HA: begin
					if (ha_pass | hao_ovr)
						st_q <= ST_XFER;
				end
				ST_XFER: begin
					if (cyl_step) begin
						head_q      <= 6'(head_q + 6'h01);
						head_load_q <= 1'b1;
						nxt_q       <= 1'b1;
						st_q        <= ST_SEEK_HA;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
			if (fin) begin
				st_q     <= ST_IDLE;
				op_end_q <= 1'b1;
			end
		end
	end

	// Status word flags; a set in the same cycle as a clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			end_n_q <= 1'b0;
			end_u_q <= 1'b0;
			nrf_q   <= 1'b0;
			dc_q    <= 1'b0;
			inop_q  <= 1'b0;
			ovr_q   <= 1'b0;
		end else begin
			if (clr) begin
				end_n_q <= 1'b0;
				end_u_q <= 1'b0;
				nrf_q   <= 1'b0;
				dc_q    <= 1'b0;
				inop_q  <= 1'b0;
				ovr_q   <= 1'b0;
			end
			if (read_wr & (inop_now | ~valid_op)) begin
				inop_q  <= inop_now;
				end_u_q <= 1'b1;
			end
			if (dc_now & ~idle)
				dc_q <= 1'b1;
			if (nrf_set)
				nrf_q <= 1'b1;
			if (push & hold_v_q & ~move)
				ovr_q <= 1'b1;
			if (fin) begin
				end_n_q <= ~fin_u;
				end_u_q <= fin_u;
			end
		end
	end

	// Character hand-off with request spacing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q   <= '0;
			hold_v_q <= 1'b0;
			data_q   <= '0;
			srv_q    <= 1'b0;
			pace_q   <= '0;
		end else begin
			if (pace_q != 10'h000)
				pace_q <= pace_q - 10'h001;
			if (data_rd)
				srv_q <= 1'b0;
			if (move) begin
				data_q   <= hold_q;
				srv_q    <= 1'b1;
				pace_q   <= wide_q ? PACE8_CYC : PACE6_CYC;
				hold_v_q <= 1'b0;
			end
			if (push) begin
				hold_q   <= wide_q ? s2_q.ch : {2'b00, s2_q.ch[5:0]};
				hold_v_q <= 1'b1;
			end else if (read_wr)
				hold_v_q <= 1'b0;
		end
	end

	// Area character index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cidx_q <= '0;
		else if (eoa)
			cidx_q <= '0;
		else if (strb & cidx_q != 4'hF)
			cidx_q <= cidx_q + 4'h1;
	end

	logic [31:0] rdata;
	assign rdata =
		hit_ctrl ? {25'h0, wide_q, 2'b00, mode_q} :
		hit_alo  ? {8'h00, addr_q[3:0]} :
		hit_ahi  ? {8'h00, addr_q[7:4]} :
		hit_sts  ? {18'h0, head_q, ovr_q, srv_q, inop_q, dc_q, nrf_q, end_u_q, end_n_q,
			~idle} :
		hit_dat  ? {24'h0, data_q} : 32'h0000_0000;

	// Register file
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q   <= '0;
			mode_q   <= '0;
			wide_q   <= 1'b0;
			prdata_q <= '0;
		end else begin
			if (wr & hit_alo & idle)
				addr_q[3:0] <= pwdata[23:0];
			if (wr & hit_ahi & idle)
				addr_q[7:4] <= pwdata[23:0];
			if (order_wr) begin
				mode_q <= order_f;
				wide_q <= pwdata[CTRL_WIDE_BIT];
			end
			if (psel & ~penable & ~pwrite)
				prdata_q <= rdata;
		end
	end

	assign prdata        = prdata_q;
	assign pready        = 1'b1;
	assign pslverr       = acc_ph & ~mapped;
	assign head_addr     = head_q;
	assign head_load     = head_load_q;
	assign squelch       = st_q == ST_SQUELCH;
	assign access_select = acc_q;
	assign srv_req       = srv_q;
	assign op_end        = op_end_q;

endmodule

/* File: sim/disk_drive_model.sv */
// Drive side: tagged serial characters, area ends and index pulses.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps
module disk_drive_model
	import disk_read_pkg::*;
(
	input  wire logic   pclk,
	output drive_in_type drive_in
);
	initial begin
		drive_in = '0;
		drive_in.powered = 4'hF;
	end
	// Pulses last 4 clocks high and low, above the 3-clock sync minimum
	task automatic put_ch(input logic [1:0] ar, input logic [7:0] c, input int gap);
		drive_in.area <= ar;
		drive_in.ch <= c;
		repeat (1) @(posedge pclk);
		drive_in.strobe <= 1'b1;
		repeat (4) @(posedge pclk);
		drive_in.strobe <= 1'b0;
		repeat (4) @(posedge pclk);
		// Released data line must not keep showing the old character
		drive_in.ch <= ~c;
		repeat (gap) @(posedge pclk);
	endtask
	task automatic end_area(input logic err, input logic last);
		drive_in.check_err <= err;
		drive_in.last_rec <= last;
		@(posedge pclk);
		drive_in.area_end <= 1'b1;
		repeat (4) @(posedge pclk);
		drive_in.area_end <= 1'b0;
		repeat (4) @(posedge pclk);
		drive_in.area <= AREA_NONE;
		// One edge before the next area tag is driven
		@(posedge pclk);
	endtask
	task automatic index_pulse();
		drive_in.early_index <= 1'b1;
		repeat (4) @(posedge pclk);
		drive_in.early_index <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
endmodule

/* File: sim/disk_track_read_sequencer_properties.sv */
// Port assertions for the track read sequencer.
// Bound into every sequencer instance; sees its ports only.
`timescale 1ns/1ps
module disk_track_read_sequencer_properties
	import disk_read_pkg::*;
(
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [7:0]   paddr,
	input wire logic [31:0]  pwdata,
	input wire logic [31:0]  prdata,
	input wire logic         pready,
	input wire logic         pslverr,
	input wire drive_in_type drive_in,
	input wire logic [5:0]   head_addr,
	input wire logic         head_load,
	input wire logic         squelch,
	input wire logic [3:0]   access_select,
	input wire logic         srv_req,
	input wire logic         op_end
);
	logic [9:0] gap_q;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Saturates so a long quiet spell never looks like a short gap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 10'h3FF;
		end else begin
			gap_q <= $rose(srv_req) ? 10'h001 : gap_q + {9'h000, gap_q != 10'h3FF};
		end
	end
	property p_pace;
		$rose(srv_req) |-> gap_q >= 10'h217;
	endproperty
	a_pace: assert property (p_pace) else $error("requests too close");
	property p_head_hold;
		$changed(head_addr) |-> head_load || $past(head_load);
	endproperty
	a_head_hold: assert property (p_head_hold) else $error("head moved unloaded");
	property p_head_range;
		head_load |-> head_addr <= SPARE_BASE + 6'h06;
	endproperty
	a_head_range: assert property (p_head_range) else $error("head out of range");
	property p_end_pulse;
		op_end |=> !op_end;
	endproperty
	a_end_pulse: assert property (p_end_pulse) else $error("end too long");
	property p_sq_hold;
		$rose(squelch) |=> squelch [*8];
	endproperty
	a_sq_hold: assert property (p_sq_hold) else $error("squelch too short");
	property p_sq_quiet;
		squelch |-> !$rose(srv_req);
	endproperty
	a_sq_quiet: assert property (p_sq_quiet) else $error("request in squelch");
	property p_access;
		$onehot0(access_select);
	endproperty
	a_access: assert property (p_access) else $error("two accesses");
	property p_data_clr;
		psel && penable && !pwrite && paddr == OFS_DATA |=> !srv_req;
	endproperty
	a_data_clr: assert property (p_data_clr) else $error("request kept");
endmodule
bind disk_track_read_sequencer disk_track_read_sequencer_properties i_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .drive_in, .head_addr, .head_load, .squelch, .access_select,
	.srv_req, .op_end
);

/* File: sim/tb_top.sv */
// Bench: APB master, drive model, monitor comparing every read with a queue.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import disk_read_pkg::*;
	logic         pclk = 1'b0;
	logic         presetn = 1'b0;
	logic         psel = 1'b0;
	logic         penable = 1'b0;
	logic         pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00;
	logic [31:0]  pwdata = 32'h0;
	logic [31:0]  prdata, mon_e;
	logic         pready, pslverr, head_load, squelch, srv_req, op_end;
	logic [5:0]   head_addr;
	logic [3:0]   access_select;
	drive_in_type drive_in;
	int           fail_count = 0;
	int           checked = 0;
	integer       seed = 71416;
	logic [31:0]  exp_q[$];
	logic [7:0]   addr[8] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h32, 8'h21, 8'h22};
	logic [2:0]   codes[6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
	always #10 pclk = ~pclk;
	disk_track_read_sequencer i_disk_track_read_sequencer (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .drive_in,
		.head_addr, .head_load, .squelch, .access_select, .srv_req, .op_end);
	disk_drive_model i_disk_drive_model (.pclk, .drive_in);
	task automatic end_sim();
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic wait_for(input int which, input logic [5:0] h);
		int n;
		for (n = 0; n < 20000; n++) begin
			if ((which == 0 && srv_req === 1'b1) || (which == 1 && op_end === 1'b1) ||
			    (which == 2 && head_addr === h)) break;
			@(posedge pclk);
		end
		if (n == 20000) begin
			fail_count++;
			$display("ERROR %0t wait ran out", $time);
			end_sim();
		end
	endtask
	// One spare edge after release keeps back-to-back calls from racing psel
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
		if (n == 16) begin
			fail_count++;
			$display("ERROR %0t ready never came", $time);
			end_sim();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic start(input logic [3:0] op);
		apb(1'b1, OFS_CTRL, {28'h0, op});
		apb(1'b1, OFS_CTRL, 32'h10);
	endtask
	task automatic get(input int n);
		repeat (n) begin
			wait_for(0, 6'h00);
			apb(1'b0, OFS_DATA, 32'h0);
		end
	endtask
	task automatic ha(input logic [7:0] flag, input logic [7:0] d4);
		for (int i = 2; i < 8; i++) begin
			if (i == 6) i_disk_drive_model.put_ch(AREA_HA, flag, 2);
			i_disk_drive_model.put_ch(AREA_HA, i == 5 ? d4 : addr[i], 2);
		end
		i_disk_drive_model.end_area(1'b0, 1'b0);
	endtask
	task automatic ra(input logic [7:0] id2);
		for (int i = 0; i < 8; i++) i_disk_drive_model.put_ch(AREA_RA, i == 7 ? id2 : addr[i], 2);
		i_disk_drive_model.end_area(1'b0, 1'b0);
	endtask
	task automatic area(input logic [1:0] ar, input int n, input logic err, input logic last);
		logic [7:0] c;
		repeat (n) begin
			c = 8'($random(seed)) & 8'h3F;
			exp_q.push_back({26'h0, c[5:0]});
			i_disk_drive_model.put_ch(ar, c, 600);
		end
		i_disk_drive_model.end_area(err, last);
	endtask
	always @(posedge pclk) begin
		if (psel && penable && !pwrite) begin
			`CHK(pslverr, paddr > OFS_DATA)
			mon_e = exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF;
			`CHK(prdata, mon_e)
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_exp(8'h14, 32'h0);
		apb(1'b1, OFS_ADDR_LO, 32'h0000_0040);
		apb(1'b1, OFS_ADDR_HI, 32'h008A_1081);
		for (int i = 0; i < 6; i++) begin
			start(OP_TRACK);
			fork
				ha({5'h00, codes[i]}, 8'h32);
				wait_for(2, SPARE_BASE + 6'(i + 1));
			join
			apb(1'b1, OFS_CTRL, 32'h20);
			wait_for(1, 6'h00);
			rd_exp(OFS_STATUS, {18'h0, SPARE_BASE + 6'(i + 1), 8'h02});
		end
		start(OP_TRACK);
		fork
			begin
				ha(8'h00, 8'h32);
				`CHK(access_select, 4'b0010)
				area(AREA_RA, 8, 1'b0, 1'b0);
				area(AREA_REC, 2, 1'b0, 1'b1);
			end
			get(10);
			wait_for(1, 6'h00);
		join
		rd_exp(OFS_STATUS, 32'h0000_0C02);
		start(OP_TRACK);
		fork
			ha(8'h00, 8'h33);
			wait_for(1, 6'h00);
		join
		rd_exp(OFS_STATUS, 32'h0000_0C0C);
		rd_exp(OFS_STATUS, 32'h0000_0C00);
		start(OP_SINGLE);
		fork
			begin
				repeat (150) @(posedge pclk);
				ra(8'h23);
				ra(8'h22);
				area(AREA_REC, 2, 1'b1, 1'b0);
			end
			get(2);
			wait_for(1, 6'h00);
		join
		rd_exp(OFS_STATUS, 32'h0000_0C14);
		start(OP_SINGLE);
		fork
			begin
				repeat (150) @(posedge pclk);
				i_disk_drive_model.index_pulse();
				ra(8'h23);
				i_disk_drive_model.index_pulse();
			end
			wait_for(1, 6'h00);
		join
		rd_exp(OFS_STATUS, 32'h0000_0C0C);
		// Home address read in eight-bit mode: identifiers follow the flag byte
		apb(1'b1, OFS_CTRL, 32'h0000_0045);
		apb(1'b1, OFS_CTRL, 32'h0000_0010);
		exp_q.push_back(32'h0000_0021);
		exp_q.push_back(32'h0000_0022);
		fork
			begin
				ha(8'h00, 8'h32);
				repeat (800) @(posedge pclk);
				i_disk_drive_model.index_pulse();
			end
			get(2);
			wait_for(1, 6'h00);
		join
		rd_exp(OFS_STATUS, 32'h0000_0C02);
		`CHK(exp_q.size(), 0)
		end_sim();
	end
endmodule
